// File: rtl/bram_fifo_ecc.sv
/*
 * configurable 36kb dual-port ram with fifo controller, cascade and ecc.
 * registers over ahb-lite; user fabric drives both ports on i_core_clk.
 */
//
// Function
// - ports organise as 32Kx1 up to 512x72 through width codes.
// - each port has its own width code; in split read/write mode one of the two must be 36 or 72 wide.
// - split mode gives two independent 18kb halves, one per port.
// - widths above 18/36 only in split_read_write_port_mode.
// - split read/write mode: port a writes only, port b reads only.
// - in that mode one side is fixed at 32/36 or 64/72.
// - ecc on 64-bit words stores eight check bits, corrects/detects.
// - encoder and decoder usable standalone for external memories.
// - fifo capacity is 36kb or 18kb.
// - fifo advances its own read and write pointers.
// - fifo drives full, empty, almost-full and almost-empty.
// - user sets almost thresholds, flags follow them.
// - fifo write and read widths may differ.
// - cascade port chains fifos into a deeper one.
`timescale 1ns/1ns
module bram_fifo_ecc
   import bram_pkg::*;
#(
   parameter int THR_W = CNT_W
) (
   input  wire logic              i_core_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_hsel,
   input  wire logic [31:0]       i_haddr,
   input  wire logic [1:0]        i_htrans,
   input  wire logic              i_hwrite,
   input  wire logic [2:0]        i_hsize,
   input  wire logic [31:0]       i_hwdata,
   input  wire logic              i_hready,
   output logic                   o_hreadyout,
   output logic                   o_hresp,
   output logic [31:0]            o_hrdata,
   input  wire logic              i_a_en,
   input  wire logic              i_a_we,
   input  wire logic [POS_W-1:0]  i_a_addr,
   input  wire logic [WORD_W-1:0] i_a_wdata,
   output logic [WORD_W-1:0]      o_a_rdata,
   output logic                   o_a_sbe,
   output logic                   o_a_dbe,
   input  wire logic              i_b_en,
   input  wire logic              i_b_we,
   input  wire logic [POS_W-1:0]  i_b_addr,
   input  wire logic [WORD_W-1:0] i_b_wdata,
   output logic [WORD_W-1:0]      o_b_rdata,
   output logic                   o_b_sbe,
   output logic                   o_b_dbe,
   input  wire logic              i_fifo_wr,
   input  wire logic [WORD_W-1:0] i_fifo_wdata,
   input  wire logic              i_fifo_rd,
   output logic                   o_fifo_rvalid,
   output logic                   o_full,
   output logic                   o_empty,
   output logic                   o_afull,
   output logic                   o_aempty,
   input  wire logic              i_casc_in_valid,
   input  wire logic [WORD_W-1:0] i_casc_in_data,
   output logic                   o_casc_in_ready,
   input  wire logic              i_casc_out_ready,
   input  wire logic [DATA_W-1:0] i_xecc_wdata,
   output logic [7:0]             o_xecc_check,
   input  wire logic [WORD_W-1:0] i_xecc_rword,
   output logic [DATA_W-1:0]      o_xecc_rdata,
   output logic                   o_xecc_sbe,
   output logic                   o_xecc_dbe,
   output logic                   o_irq
);
   if (THR_W != CNT_W) begin : g_chk
      $error("THR_W must equal the fifo count width");
   end
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   cfg_s               cfg_q;
   logic [CNT_W-1:0]   aft_q;
   logic [CNT_W-1:0]   aet_q;
   logic [IRQ_N-1:0]   ist_q;
   logic [IRQ_N-1:0]   ien_q;
   logic [IRQ_N-1:0]   ev;
   logic               wr_q;
   logic               rd_q;
   logic [7:0]         adr_q;
   logic [POS_W-1:0]   wp_q;
   logic [POS_W-1:0]   rp_q;
   logic [CNT_W-1:0]   cnt_q;
   logic [CNT_W-1:0]   cnt_d;
   logic [WORD_W-1:0]  mem [DEPTH];
   logic [2:0]         mx;
   logic               cfg_ok;
   logic               fifo_on;
   logic [CNT_W-1:0]   cap;
   logic [CNT_W-1:0]   wstep;
   logic [CNT_W-1:0]   rstep;
   logic               full;
   logic               empty;
   logic               wsrc_v;
   logic [WORD_W-1:0]  wsrc_d;
   logic               rreq;
   logic               wr_ok;
   logic               rd_ok;
   logic               take;
   logic               wen;
   logic               cfg_wr;
   logic [31:0]        rval;
   acc_s               a;
   acc_s               b;
   logic [WADR_W-1:0]  wa;
   logic [WADR_W-1:0]  wb;
   rd_s                rda;
   rd_s                rdb;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // split mode puts port b in the upper half
   function automatic logic [WADR_W-1:0] word_of(input acc_s x, input logic sp);
      return sp ? {x.side, x.pos[POS_W-2:LANE_W]} : x.pos[POS_W-1:LANE_W];
   endfunction
   function automatic logic [6:0] off_of(input acc_s x);
      logic [LANE_W-1:0] ln;
      ln = x.pos[LANE_W-1:0] >> x.code;
      return 7'({1'b0, ln} * lane_w(x.code));
   endfunction
   function automatic logic [WORD_W-1:0] msk(input logic [2:0] c);
      return (WORD_W'(1) << lane_w(c)) - WORD_W'(1);
   endfunction
   function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old,
                                               input acc_s x, input logic e);
      logic [WORD_W-1:0] m;
      m = msk(x.code) << off_of(x);
      if (e && x.code == CODE_72)
         return {ecc_enc(x.wd[DATA_W-1:0]), x.wd[DATA_W-1:0]};
      return (old & ~m) | ((x.wd << off_of(x)) & m);
   endfunction
   function automatic rd_s port_rd(input logic [WORD_W-1:0] raw, input acc_s x,
                                   input logic e);
      rd_s r;
      r = '0;
      if (e && x.code == CODE_72) r = ecc_dec(raw);
      else r.d = (raw >> off_of(x)) & msk(x.code);
      return r;
   endfunction
   // ----------------------------------------------------------------
   // configuration check
   // ----------------------------------------------------------------
   // an illegal width pair freezes both ports and the fifo
   assign mx     = (cfg_q.split ? MAX_HALF : MAX_FULL) + {2'h0, cfg_q.srw};
   assign cfg_ok = cfg_q.a_code <= mx && cfg_q.b_code <= mx
                   && (!cfg_q.srw || cfg_q.a_code >= CODE_36
                       || cfg_q.b_code >= CODE_36);
   // ----------------------------------------------------------------
   // fifo control
   // ----------------------------------------------------------------
   // count in 1/64-word units so mixed widths share one scale
   assign fifo_on = cfg_q.fifo & cfg_ok;
   assign cap     = cfg_q.split ? CAP_HALF : CAP_FULL;
   assign wstep   = CNT_W'(1) << cfg_q.a_code;
   assign rstep   = CNT_W'(1) << cfg_q.b_code;
   assign full    = (cap - cnt_q) < wstep;
   assign empty   = cnt_q < rstep;
   assign wsrc_v  = cfg_q.casc_in ? i_casc_in_valid : i_fifo_wr;
   assign wsrc_d  = cfg_q.casc_in ? i_casc_in_data : i_fifo_wdata;
   assign rreq    = cfg_q.casc_out ? i_casc_out_ready : i_fifo_rd;
   assign wr_ok   = fifo_on & wsrc_v & ~full;
   assign rd_ok   = fifo_on & rreq & ~empty;
   assign cnt_d   = cfg_wr ? '0 : cnt_q + (wr_ok ? wstep : '0)
                              - (rd_ok ? rstep : '0);
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (cfg_wr) begin
            wp_q <= '0;
            rp_q <= '0;
         end else begin
            if (wr_ok) wp_q <= POS_W'((wp_q + wstep) & (cap - 16'h1));
            if (rd_ok) rp_q <= POS_W'((rp_q + rstep) & (cap - 16'h1));
         end
         cnt_q <= cnt_d;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_full          <= 1'b0;
         o_empty         <= 1'b1;
         o_afull         <= 1'b0;
         o_aempty        <= 1'b1;
         o_casc_in_ready <= 1'b0;
         o_fifo_rvalid   <= 1'b0;
      end else begin
         o_full          <= (cap - cnt_d) < wstep;
         o_empty         <= cnt_d < rstep;
         o_afull         <= cnt_d >= aft_q;
         o_aempty        <= cnt_d <= aet_q;
         o_casc_in_ready <= fifo_on & cfg_q.casc_in
                            & ((cap - cnt_d) >= (wstep << 1));
         o_fifo_rvalid   <= rd_ok;
      end
   end
   // ----------------------------------------------------------------
   // port access mux
   // ----------------------------------------------------------------
   // srw mode blocks port a reads and port b writes at the enable
   always_comb begin
      if (cfg_q.fifo) begin
         a = '{wr_ok, 1'b1, 1'b0, cfg_q.a_code, wp_q, wsrc_d};
         b = '{rd_ok, 1'b0, 1'b0, cfg_q.b_code, rp_q, '0};
      end else begin
         a = '{i_a_en & cfg_ok & ~(cfg_q.srw & ~i_a_we), i_a_we, 1'b0,
               cfg_q.a_code, POS_W'(i_a_addr << cfg_q.a_code), i_a_wdata};
         b = '{i_b_en & cfg_ok & ~(cfg_q.srw & i_b_we), i_b_we, 1'b1,
               cfg_q.b_code, POS_W'(i_b_addr << cfg_q.b_code), i_b_wdata};
      end
   end
   assign wa  = word_of(a, cfg_q.split & ~cfg_q.fifo);
   assign wb  = word_of(b, cfg_q.split & ~cfg_q.fifo);
   assign rda = port_rd(mem[wa], a, cfg_q.ecc);
   assign rdb = port_rd(mem[wb], b, cfg_q.ecc);
   // ----------------------------------------------------------------
   // memory array
   // ----------------------------------------------------------------
   // port b is written last, so it wins a same-word collision
   always_ff @(posedge i_core_clk) begin
      if (a.en & a.we) mem[wa] <= merge(mem[wa], a, cfg_q.ecc);
      if (b.en & b.we) mem[wb] <= merge(mem[wb], b, cfg_q.ecc);
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_a_rdata <= '0;
         o_a_sbe   <= 1'b0;
         o_a_dbe   <= 1'b0;
      end else if (a.en & ~a.we) begin
         {o_a_rdata, o_a_sbe, o_a_dbe} <= rda;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_b_rdata <= '0;
         o_b_sbe   <= 1'b0;
         o_b_dbe   <= 1'b0;
      end else if (b.en & ~b.we) begin
         {o_b_rdata, o_b_sbe, o_b_dbe} <= rdb;
      end
   end
   // ----------------------------------------------------------------
   // standalone ecc
   // ----------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         // independent of the array, serves external 64/72-bit memories
         o_xecc_check <= '0;
         o_xecc_rdata <= '0;
         o_xecc_sbe   <= 1'b0;
         o_xecc_dbe   <= 1'b0;
      end else begin
         o_xecc_check <= ecc_enc(i_xecc_wdata);
         {o_xecc_rdata, o_xecc_sbe, o_xecc_dbe} <=
            {ecc_dec(i_xecc_rword).d[DATA_W-1:0], ecc_dec(i_xecc_rword).sbe,
             ecc_dec(i_xecc_rword).dbe};
      end
   end
   // ----------------------------------------------------------------
   // ahb-lite slave
   // ----------------------------------------------------------------
   // reads wait one cycle so register data leaves a flop
   assign take   = i_hsel & i_htrans[1] & i_hready;
   assign wen    = wr_q;
   assign cfg_wr = wen && adr_q == OFS_CFG;
   always_comb begin
      case (adr_q)
         OFS_CFG:  rval = {20'h0, cfg_q};
         OFS_AFT:  rval = {16'h0, aft_q};
         OFS_AET:  rval = {16'h0, aet_q};
         OFS_STAT: rval = {11'h0, ~cfg_ok, o_aempty, o_afull, o_empty, o_full, cnt_q};
         OFS_IST:  rval = {28'h0, ist_q};
         OFS_IEN:  rval = {28'h0, ien_q};
         default:  rval = '0;
      endcase
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_q        <= 1'b0;
         rd_q        <= 1'b0;
         adr_q       <= '0;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         o_hrdata    <= '0;
      end else begin
         wr_q <= take & i_hwrite;
         rd_q <= take & ~i_hwrite;
         if (take) adr_q <= i_haddr[7:0];
         o_hreadyout <= ~(take & ~i_hwrite);
         if (rd_q) o_hrdata <= rval;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_q <= '0;
         aft_q <= AFT_RST;
         aet_q <= AET_RST;
         ien_q <= '0;
      end else if (wen) begin
         case (adr_q)
            OFS_CFG: cfg_q <= cfg_s'(i_hwdata[$bits(cfg_s)-1:0]);
            OFS_AFT: aft_q <= i_hwdata[CNT_W-1:0];
            OFS_AET: aet_q <= i_hwdata[CNT_W-1:0];
            OFS_IEN: ien_q <= i_hwdata[IRQ_N-1:0];
            default: ;
         endcase
      end
   end
   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   always_comb begin
      ev          = '0;
      ev[IRQ_SBE] = (a.en & ~a.we & rda.sbe) | (b.en & ~b.we & rdb.sbe);
      ev[IRQ_DBE] = (a.en & ~a.we & rda.dbe) | (b.en & ~b.we & rdb.dbe);
      ev[IRQ_OVF] = fifo_on & wsrc_v & full;
      // a downstream stage pulling an empty fifo is not an error
      ev[IRQ_UDF] = fifo_on & ~cfg_q.casc_out & rreq & empty;
   end
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ist_q <= '0;
         o_irq <= 1'b0;
      end else begin
         // set wins over a clear in the same cycle
         ist_q <= (ist_q & ~((wen && adr_q == OFS_ICLR) ? i_hwdata[IRQ_N-1:0] : '0))
                  | ev;
         o_irq <= |(((ist_q & ~((wen && adr_q == OFS_ICLR)
                     ? i_hwdata[IRQ_N-1:0] : '0)) | ev) & ien_q);
      end
   end
endmodule // bram_fifo_ecc

// File: rtl/bram_pkg.sv
/*
 * constants, carrier types and ecc functions of the dual-port ram / fifo block.
 * assumes a single core clock and one 72-bit memory word per address.
 */
package bram_pkg;
   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int          WORD_W   = 72;
   localparam int          DATA_W   = 64;
   localparam int          DEPTH    = 512;
   localparam int          POS_W    = 15;
   localparam int          WADR_W   = 9;
   localparam int          LANE_W   = 6;
   localparam int          PBITS    = 7;
   localparam int          CNT_W    = 16;
   localparam logic [2:0]  CODE_36  = 3'h5;
   localparam logic [2:0]  CODE_72  = 3'h6;
   localparam logic [2:0]  MAX_FULL = 3'h5;
   localparam logic [2:0]  MAX_HALF = 3'h4;
   localparam logic [15:0] CAP_FULL = 16'h8000;
   localparam logic [15:0] CAP_HALF = 16'h4000;
   localparam logic [15:0] AFT_RST  = 16'h7c00;
   localparam logic [15:0] AET_RST  = 16'h0400;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  OFS_CFG  = 8'h00;
   localparam logic [7:0]  OFS_AFT  = 8'h04;
   localparam logic [7:0]  OFS_AET  = 8'h08;
   localparam logic [7:0]  OFS_STAT = 8'h0c;
   localparam logic [7:0]  OFS_IST  = 8'h10;
   localparam logic [7:0]  OFS_ICLR = 8'h14;
   localparam logic [7:0]  OFS_IEN  = 8'h18;
   localparam int          IRQ_N    = 4;
   localparam int          IRQ_SBE  = 0;
   localparam int          IRQ_DBE  = 1;
   localparam int          IRQ_OVF  = 2;
   localparam int          IRQ_UDF  = 3;
   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       casc_out;
      logic       casc_in;
      logic [2:0] b_code;
      logic [2:0] a_code;
      logic       ecc;
      logic       srw;
      logic       split;
      logic       fifo;
   } cfg_s;
   typedef struct packed {
      logic              en;
      logic              we;
      logic              side;
      logic [2:0]        code;
      logic [POS_W-1:0]  pos;
      logic [WORD_W-1:0] wd;
   } acc_s;
   typedef struct packed {
      logic [WORD_W-1:0] d;
      logic              sbe;
      logic              dbe;
   } rd_s;
   // ----------------------------------------------------------------
   // hamming secded over 64 data bits, check bits in [71:64]
   // ----------------------------------------------------------------
   function automatic logic [7:0] ecc_enc(input logic [DATA_W-1:0] d);
      logic [WORD_W-1:0] cw;
      logic [7:0]        c;
      int                j;
      cw = '0;
      c  = '0;
      j  = 0;
      for (int p = 1; p < WORD_W; p++) if ((p & (p - 1)) != 0) begin
         cw[p] = d[j];
         j++;
      end
      for (int p = 1; p < WORD_W; p++)
         for (int b = 0; b < PBITS; b++) if (p[b]) c[b] ^= cw[p];
      c[7] = ^{c[6:0], d};
      return c;
   endfunction
   function automatic rd_s ecc_dec(input logic [WORD_W-1:0] w);
      logic [WORD_W-1:0] cw;
      logic [6:0]        s;
      rd_s               r;
      int                j;
      cw = '0;
      s  = '0;
      r  = '0;
      j  = 0;
      for (int b = 0; b < PBITS; b++) cw[1 << b] = w[DATA_W + b];
      for (int p = 1; p < WORD_W; p++) if ((p & (p - 1)) != 0) begin
         cw[p] = w[j];
         j++;
      end
      for (int p = 1; p < WORD_W; p++)
         for (int b = 0; b < PBITS; b++) if (p[b]) s[b] ^= cw[p];
      if (s == '0) r.sbe = ^w;
      else if ((^w) && s < 7'd72) begin
         cw[s] = ~cw[s];
         r.sbe = 1'b1;
      end else r.dbe = 1'b1;
      j = 0;
      for (int p = 1; p < WORD_W; p++) if ((p & (p - 1)) != 0) begin
         r.d[j] = cw[p];
         j++;
      end
      r.d[WORD_W-1:DATA_W] = w[WORD_W-1:DATA_W];
      return r;
   endfunction
   // lane width per organisation code
   function automatic logic [6:0] lane_w(input logic [2:0] c);
      case (c)
         3'h0:    return 7'h01;
         3'h1:    return 7'h02;
         3'h2:    return 7'h04;
         3'h3:    return 7'h09;
         3'h4:    return 7'h12;
         3'h5:    return 7'h24;
         default: return 7'h48;
      endcase
   endfunction
endpackage

// File: tb/bram_fifo_ecc_monitor.sv
/* port assertions of the ram/fifo block.
   assumes one core clock and an active-low reset. */
`timescale 1ns/1ns
module bram_fifo_ecc_monitor
   import bram_pkg::*;
(
   input wire logic              i_core_clk,
   input wire logic              i_rst_n,
   input wire logic              i_hsel,
   input wire logic [1:0]        i_htrans,
   input wire logic              i_hwrite,
   input wire logic              i_hready,
   input wire logic              o_hreadyout,
   input wire logic              o_hresp,
   input wire logic              i_fifo_wr,
   input wire logic              i_fifo_rd,
   input wire logic              i_casc_in_valid,
   input wire logic              i_casc_out_ready,
   input wire logic              o_fifo_rvalid,
   input wire logic              o_full,
   input wire logic              o_empty,
   input wire logic              o_b_sbe,
   input wire logic              o_b_dbe,
   input wire logic [DATA_W-1:0] i_xecc_wdata,
   input wire logic [7:0]        o_xecc_check,
   input wire logic [WORD_W-1:0] i_xecc_rword,
   input wire logic [DATA_W-1:0] o_xecc_rdata,
   input wire logic              o_xecc_sbe,
   input wire logic              o_xecc_dbe
);
   wire logic        take  = i_hsel && i_htrans[1] && i_hready;
   wire logic [63:0] rw_lo = i_xecc_rword[63:0];
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // ------
   // checks
   // ------
   bus_okay_a: assert property (o_hresp == 1'b0)
      else $error("bus response not okay");
   write_nowait_a: assert property (take && i_hwrite |=> o_hreadyout)
      else $error("write phase stalled");
   read_wait_a: assert property (take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
      else $error("read phase length wrong");
   pop_cause_a: assert property (
      o_fifo_rvalid |-> ($past(i_fifo_rd) || $past(i_casc_out_ready)) && !$past(o_empty))
      else $error("data popped without request");
   full_hold_a: assert property (
      o_full && !i_fifo_rd && !i_casc_out_ready |=> o_full)
      else $error("full dropped without pop");
   empty_hold_a: assert property (
      o_empty && !i_fifo_wr && !i_casc_in_valid |=> o_empty)
      else $error("empty dropped without push");
   flag_excl_a: assert property (!(o_full && o_empty))
      else $error("full and empty together");
   ecc_trip_a: assert property (
      i_xecc_rword == {o_xecc_check, $past(i_xecc_wdata)} |=>
      o_xecc_rdata == $past(rw_lo) && !o_xecc_sbe && !o_xecc_dbe)
      else $error("clean codeword not returned");
   err_excl_a: assert property (!(o_b_sbe && o_b_dbe) && !(o_xecc_sbe && o_xecc_dbe))
      else $error("both error kinds flagged");
   cover property (take && !i_hwrite);
   cover property (o_fifo_rvalid);
   cover property (o_full);
   cover property (o_xecc_sbe);
endmodule // bram_fifo_ecc_monitor
bind bram_fifo_ecc bram_fifo_ecc_monitor mon_u (.*);

// File: tb/fifo_fabric_model.sv
/* fabric-side fifo writer: pushes a counting pattern on command.
   assumes full is a registered level from the fifo. */
`timescale 1ns/1ns
module fifo_fabric_model
   import bram_pkg::*;
(
   input  wire logic         i_core_clk,
   input  wire logic         i_go,
   input  wire logic         i_pushy,
   input  wire logic         i_full,
   output logic              o_wr,
   output logic [WORD_W-1:0] o_wdata
);
   logic [31:0] n_q;
   initial n_q = 32'h0;
   // holds off while full unless told to overrun
   assign o_wr    = i_go && (i_pushy || !i_full);
   // idle data is the inverse, never a stale copy
   assign o_wdata = o_wr ? {n_q[7:0], ~n_q, n_q} : ~{n_q[7:0], ~n_q, n_q};
   always_ff @(posedge i_core_clk) if (o_wr && !i_full) n_q <= n_q + 32'h1;
endmodule // fifo_fabric_model

// File: tb/test_dual_port_ram_fifo_ecc.sv
/* bench of the ram/fifo block: registers, ram ports, fifo and ecc.
   assumes the bound monitor and the fabric model beside the block. */
`timescale 1ns/1ns
module test_dual_port_ram_fifo_ecc
   import bram_pkg::*;
;
   logic        clk, rst_n, hsel, hwrite, hrdy, a_en, a_we, b_en, b_we, fifo_rd, go;
   logic        pushy, fwr, rvalid, full, xsbe, xdbe, b_sbe, b_dbe, irq, cready;
   logic [71:0] a_rd;
   logic [1:0]  htrans;
   logic [7:0]  xchk;
   logic [14:0] addr;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [63:0] xwd, xrd;
   logic [71:0] wd, b_rd, fwd, xrw;
   int          failures, cmp_count;
   logic [31:0] th [3] = '{32'h0008_0020, 32'h0000_0040, 32'h0004_0060};
   int          lw [7] = '{1, 2, 4, 9, 18, 36, 72};
   bram_fifo_ecc dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
      .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(), .o_hrdata(hrdata), .i_a_en(a_en),
      .i_a_we(a_we), .i_a_addr(addr), .i_a_wdata(wd), .o_a_rdata(a_rd), .o_a_sbe(), .o_a_dbe(),
      .i_b_en(b_en), .i_b_we(b_we), .i_b_addr(addr), .i_b_wdata(wd), .o_b_rdata(b_rd),
      .o_b_sbe(b_sbe), .o_b_dbe(b_dbe), .i_fifo_wr(fwr), .i_fifo_wdata(fwd),
      .i_fifo_rd(fifo_rd), .o_fifo_rvalid(rvalid), .o_full(full), .o_empty(), .o_afull(),
      .o_aempty(), .i_casc_in_valid(fwr), .i_casc_in_data(fwd), .o_casc_in_ready(cready),
      .i_casc_out_ready(fifo_rd), .i_xecc_wdata(xwd), .o_xecc_check(xchk), .i_xecc_rword(xrw),
      .o_xecc_rdata(xrd), .o_xecc_sbe(xsbe), .o_xecc_dbe(xdbe), .o_irq(irq));
   fifo_fabric_model fab_u (.i_core_clk(clk), .i_go(go), .i_pushy(pushy), .i_full(full),
      .o_wr(fwr), .o_wdata(fwd));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ------
   // helpers
   // ------
   task automatic summarize();
      $display("mismatches %0d, comparisons %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hrdy !== 1'b1 && k < 40);
      if (hrdy !== 1'b1) begin
         failures++;
         summarize();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h0, a};
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(72'(rd), 72'(e));
   endtask
   task automatic ram(input logic p, input logic w, input logic [14:0] ad, input logic [71:0] d);
      a_en <= !p;
      b_en <= p;
      a_we <= w;
      b_we <= w;
      addr <= ad;
      wd   <= d;
      @(posedge clk);
      a_en <= 1'b0;
      b_en <= 1'b0;
      @(posedge clk);
   endtask
   // ------
   // scenarios
   // ------
   task automatic t_reset();
      rchk(OFS_CFG, 32'h0);
      rchk(OFS_AFT, {16'h0, AFT_RST});
      rchk(OFS_AET, {16'h0, AET_RST});
      rchk(OFS_STAT, 32'h000a_0000);
      rchk(8'h1c, 32'h0);
   endtask
   task automatic t_codes();
      logic [71:0] m;
      for (int c = 0; c < 7; c++) begin
         bus(1'b1, OFS_CFG, {22'h0, c[2:0], c[2:0], 1'b0, c == 6, 2'b00});
         m = (72'h1 << lw[c]) - 72'h1;
         ram(1'b0, 1'b1, 15'h1, 72'h5a_c31e_96b4_d2f0_e187);
         ram(1'b1, 1'b0, 15'h1, 72'h0);
         chk(b_rd & m, 72'h5a_c31e_96b4_d2f0_e187 & m);
         ram(1'b0, 1'b0, 15'h1, 72'h0);
         if (c < 6) chk(a_rd & m, 72'h5a_c31e_96b4_d2f0_e187 & m);
      end
   endtask
   task automatic t_srw();
      bus(1'b1, OFS_CFG, 32'h0000_0368);
      rchk(OFS_STAT, 32'h001a_0000);
      bus(1'b1, OFS_CFG, 32'h0000_036c);
      ram(1'b0, 1'b1, 15'h5, 72'hff_0123_4567_89ab_cdef);
      ram(1'b1, 1'b1, 15'h5, 72'h0);
      ram(1'b1, 1'b0, 15'h5, 72'h0);
      chk({b_sbe, b_dbe, b_rd[63:0]}, {2'b00, 64'h0123_4567_89ab_cdef});
   endtask
   task automatic t_fifo();
      logic [31:0] n;
      int          k;
      bus(1'b1, OFS_CFG, 32'h0000_02d1);
      bus(1'b1, OFS_AFT, 32'h60);
      bus(1'b1, OFS_AET, 32'h20);
      bus(1'b1, OFS_IEN, 32'h4);
      for (int i = 0; i < 3; i++) begin
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         rchk(OFS_STAT, th[i]);
      end
      go <= 1'b1;
      k = 0;
      while (full !== 1'b1 && k < 1100) begin
         @(posedge clk);
         k++;
      end
      if (full !== 1'b1) begin
         failures++;
         summarize();
      end
      pushy <= 1'b1;
      repeat (2) @(posedge clk);
      go    <= 1'b0;
      pushy <= 1'b0;
      rchk(OFS_STAT, 32'h0005_8000);
      rchk(OFS_IST, 32'h4);
      chk(72'(irq), 72'h1);
      bus(1'b1, OFS_ICLR, 32'h4);
      rchk(OFS_IST, 32'h0);
      chk(72'(irq), 72'h0);
      fifo_rd <= 1'b1;
      for (int i = 0; i <= 1024; i++) begin
         @(posedge clk);
         n = i - 1;
         if (i > 0) chk({rvalid, b_rd[35:0]}, {1'b1, ~n[3:0], n});
      end
      fifo_rd <= 1'b0;
      rchk(OFS_STAT, 32'h000a_0000);
      rchk(OFS_IST, 32'h8);
      chk(72'(irq), 72'h0);
   endtask
   task automatic t_casc();
      bus(1'b1, OFS_CFG, 32'h0000_0ed1);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      chk({cready, 71'(full)}, {1'b1, 71'h0});
      fifo_rd <= 1'b1;
      @(posedge clk);
      fifo_rd <= 1'b0;
      @(posedge clk);
      chk({rvalid, b_rd[35:0]}, {1'b1, 36'hf_0000_0400});
   endtask
   task automatic t_xecc();
      logic [71:0] cw;
      xwd <= 64'h0123_4567_89ab_cdef;
      repeat (2) @(posedge clk);
      cw = {xchk, xwd};
      for (int k = 0; k < 72; k += 7) begin
         xrw <= cw ^ (72'h1 << k);
         repeat (2) @(posedge clk);
         chk({xsbe, xdbe, xrd}, {2'b10, xwd});
         xrw <= cw ^ (72'h3 << k);
         repeat (2) @(posedge clk);
         chk({xsbe, xdbe}, 72'h1);
      end
      xrw <= cw;
      repeat (2) @(posedge clk);
      chk({xsbe, xdbe, xrd}, {2'b00, xwd});
   endtask
   initial begin
      failures  = 0;
      cmp_count = 0;
      {rst_n, hsel, hwrite, a_en, a_we, b_en, b_we, fifo_rd, go, pushy} = '0;
      {htrans, haddr, hwdata, addr, wd, xwd, xrw} = '0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_codes();
      t_srw();
      t_fifo();
      t_casc();
      t_xecc();
      summarize();
   end
endmodule // test_dual_port_ram_fifo_ecc
